// ### hdl/glyph_ram_bank.sv
// One byte-wide bank of the font RAM with per-bit write mask
module glyph_ram_bank (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic [7:0] we_mask,
    input wire logic [osd_glyph_pkg::BANK_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read side
    input wire logic [osd_glyph_pkg::BANK_AW-1:0] raddr,
    output logic [7:0] rdata
);
    import osd_glyph_pkg::*;

    logic [7:0] mem [0:(1<<BANK_AW)-1];

    // Only the unmasked bits change
    always_ff @(posedge clk) begin
        if (|we_mask) begin
            mem[waddr] <= (mem[waddr] & ~we_mask) | (wdata & we_mask);
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule

// ### hdl/osd_font_glyph_source.sv
// Glyph source: ROM, generated and RAM glyph pixels, font RAM loading
// ------------------------------------------------------------------
// How it works
// (RL1) Indices 000H-15FH are fixed ROM glyphs of native size 12x18.
// (RL2) ROM glyphs are centred in larger cells and cropped in smaller ones.
// (RL3) Indices 160H-1F6H are generated at the programmed cell size.
// (RL4) Border glyphs are fixed scaled shapes; sliders follow slider registers.
// (RL5) ROM index ranges split into multicolour and single-colour groups.
// (RL6) Geometry A: low nibble slider offset, high nibble border thickness.
// (RL7) Geometry B gap nibble sets the gap between border and core.
// (RL8) Style 0 fills middle parts solidly; style 1 draws one marker.
// (RL9) Slider start at 1D2H/1F6H, end at 1E3H/1E4H.
// (RL10) Middle parts use 16 pixels per cell, scaled to the cell.
// (RL11) 4 kbyte glyph RAM, one cell size from 8x8 to 32x32.
// (RL12) RAM stores one bit per mono pixel, two per multicolour pixel.
// (RL13) Mono pixel 0 is background, 1 is foreground.
// (RL14) Multicolour pixel is a palette index of four colours.
// (RL15) RAM holds up to 512 mono 8x8 glyphs by 9-bit index.
// (RL16) Multicolour glyphs from address 0, below the mono start index.
// (RL17) Controller sets start 000H for mono only, bit 8 for multi only.
// (RL18) Glyph defined by select then masked data bytes; masked bits kept.
// (RL19) Controller sends pixels MSB first, row by row.
// (RL20) Controller repeats data writes until the glyph is complete.
// (RL21) Select write recomputes bit address; data write advances eight.
// (RL22) Single-glyph flag masks writes past the glyph end.
// (RL23) Subaddress stays on the data register after each data write.
// (RL24) Index equal to the mono start index is single colour.
// ------------------------------------------------------------------
module osd_font_glyph_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port from the I2C-bus slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [7:0] reg_next_addr,
    // Pixel request
    input wire logic px_valid,
    input wire logic px_rom,
    input wire logic [osd_glyph_pkg::IDX_W-1:0] px_index,
    input wire logic [osd_glyph_pkg::POS_W-1:0] px_x,
    input wire logic [osd_glyph_pkg::POS_W-1:0] px_y,
    // Font ROM port
    output logic [osd_glyph_pkg::IDX_W-1:0] rom_index,
    output logic [osd_glyph_pkg::POS_W-1:0] rom_row,
    input wire logic [23:0] rom_bits,
    // Pixel result
    output logic pix_valid,
    output logic [1:0] pix_code,
    output logic pix_multi,
    output logic pix_blank
);
    import osd_glyph_pkg::*;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic wr_cw, wr_ch, wr_ga, wr_gb, wr_ms_lo, wr_ms_hi;
    logic wr_sel_lo, wr_sel_hi, wr_sel, wr_mask, wr_dat;
    assign wr_cw = reg_wr && reg_addr == REG_CELL_W;
    assign wr_ch = reg_wr && reg_addr == REG_CELL_H;
    assign wr_ga = reg_wr && reg_addr == REG_GEO_A;
    assign wr_gb = reg_wr && reg_addr == REG_GEO_B;
    assign wr_ms_lo = reg_wr && reg_addr == REG_MS_LO;
    assign wr_ms_hi = reg_wr && reg_addr == REG_MS_HI;
    assign wr_sel_lo = reg_wr && reg_addr == REG_SEL_LO;
    assign wr_sel_hi = reg_wr && reg_addr == REG_SEL_HI;
    assign wr_sel = wr_sel_lo || wr_sel_hi;
    assign wr_mask = reg_wr && reg_addr == REG_MASK;
    assign wr_dat = reg_wr && reg_addr == REG_DATA;

    logic [5:0] cw_q, ch_q;
    logic [7:0] ga_q, gb_q, mask_q, rdata_q, next_q;
    logic [8:0] ms_q, sel_q, sel_d;
    logic single_q, single_d;

    assign sel_d = wr_sel_lo ? {sel_q[8], reg_wdata}
        : (wr_sel_hi ? {reg_wdata[0], sel_q[7:0]} : sel_q);
    assign single_d = wr_sel_hi ? reg_wdata[SEL_SINGLE_BIT] : single_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cw_q <= CELL_W_RST;
            ch_q <= CELL_H_RST;
            ga_q <= GEO_RST;
            gb_q <= GEO_RST;
        end else begin
            cw_q <= wr_cw ? reg_wdata[5:0] : cw_q;
            ch_q <= wr_ch ? reg_wdata[5:0] : ch_q;
            ga_q <= wr_ga ? reg_wdata : ga_q; // RL6
            gb_q <= wr_gb ? reg_wdata : gb_q; // RL7
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ms_q <= MS_RST;
            sel_q <= MS_RST;
            single_q <= 1'b0;
            mask_q <= MASK_RST;
        end else begin
            ms_q[7:0] <= wr_ms_lo ? reg_wdata : ms_q[7:0];
            ms_q[8] <= wr_ms_hi ? reg_wdata[0] : ms_q[8];
            sel_q <= sel_d;
            single_q <= single_d;
            mask_q <= wr_mask ? reg_wdata : mask_q;
        end
    end

    // ------------------------------------------------------------
    // Bit-exact glyph base address
    // ------------------------------------------------------------
    logic [10:0] cell_bits;
    assign cell_bits = 11'(cw_q * ch_q); // RL11

    // Multicolour glyphs first, two bits a pixel, then mono glyphs
    function automatic logic [20:0] glyph_base(input logic [8:0] idx,
        input logic [8:0] ms, input logic [10:0] cb);
        logic [20:0] i, m, c;
        i = 21'(idx);
        m = 21'(ms);
        c = 21'(cb);
        if (idx < ms) begin
            glyph_base = 21'(i * c) << 1; // RL16
        end else begin
            glyph_base = (21'(m * c) << 1) + 21'((i - m) * c); // RL24
        end
    endfunction

    logic [20:0] sel_base, sel_len, cur_q, end_q;
    assign sel_base = glyph_base(sel_d, ms_q, cell_bits);
    assign sel_len = (sel_d < ms_q) ? {9'h000, cell_bits, 1'b0}
        : {10'h000, cell_bits}; // RL12

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur_q <= '0;
            end_q <= '0;
        end else if (wr_sel) begin
            cur_q <= sel_base; // RL21
            end_q <= sel_base + sel_len;
        end else if (wr_dat) begin
            cur_q <= cur_q + BYTE_STEP; // RL21
        end
    end

    // ------------------------------------------------------------
    // Masked data write across two byte lanes
    // ------------------------------------------------------------
    logic [15:0] win_d, win_m, bit_ok, wmask;
    logic [11:0] wb0, wb1;
    assign win_d = {reg_wdata, 8'h00} >> cur_q[2:0];
    assign win_m = {mask_q, 8'h00} >> cur_q[2:0]; // RL18
    assign wb0 = cur_q[14:3];
    assign wb1 = wb0 + 12'h001;

    for (genvar j = 0; j < 16; j++) begin : g_bit
        logic [20:0] a;
        assign a = {cur_q[20:3], 3'b000} + 21'(15 - j);
        assign bit_ok[j] = (a < RAM_BITS) && (!single_q || a < end_q); // RL22
    end
    assign wmask = wr_dat ? (win_m & bit_ok) : 16'h0000; // RL18

    // ------------------------------------------------------------
    // Pixel address for RAM glyphs
    // ------------------------------------------------------------
    logic [10:0] px_n;
    logic [20:0] rd_addr;
    logic [11:0] rd_byte;
    logic rd_multi;
    logic [7:0] bank_rd [2];
    assign px_n = 11'(px_y * cw_q) + 11'(px_x); // RL19
    assign rd_multi = px_index < ms_q; // RL16
    assign rd_addr = glyph_base(px_index, ms_q, cell_bits)
        + (rd_multi ? {9'h000, px_n, 1'b0} : {10'h000, px_n});
    assign rd_byte = rd_addr[14:3];

    // Even bank holds even bytes, so a straddling byte hits both banks
    for (genvar k = 0; k < 2; k++) begin : g_bank
        logic hi;
        assign hi = wb0[0] == 1'(k);
        glyph_ram_bank u_bank (
            .clk(clk),
            .we_mask(hi ? wmask[15:8] : wmask[7:0]),
            .waddr(hi ? wb0[11:1] : wb1[11:1]),
            .wdata(hi ? win_d[15:8] : win_d[7:0]),
            .raddr(rd_byte[11:1]),
            .rdata(bank_rd[k])
        );
    end

    // ------------------------------------------------------------
    // ROM centring and source selection
    // ------------------------------------------------------------
    logic signed [6:0] rom_dx, rom_dy, rom_col, rom_rw;
    logic rom_in, in_cell, blank0, multi0;
    logic [1:0] gen_code;
    src_e src0;
    assign rom_dx = ($signed({1'b0, cw_q}) - $signed({1'b0, ROM_W})) >>> 1;
    assign rom_dy = ($signed({1'b0, ch_q}) - $signed({1'b0, ROM_H})) >>> 1;
    assign rom_col = $signed({2'b00, px_x}) - rom_dx; // RL2
    assign rom_rw = $signed({2'b00, px_y}) - rom_dy; // RL2
    assign rom_in = rom_col >= 0 && rom_col < $signed({1'b0, ROM_W})
        && rom_rw >= 0 && rom_rw < $signed({1'b0, ROM_H});
    assign in_cell = {1'b0, px_x} < cw_q && {1'b0, px_y} < ch_q; // RL3
    assign src0 = !px_rom ? SRC_RAM
        : (px_index <= ROM_LAST ? SRC_ROM // RL1
        : (px_index <= GEN_LAST ? SRC_GEN : SRC_NONE)); // RL3
    assign blank0 = !in_cell || src0 == SRC_NONE
        || (src0 == SRC_ROM && !rom_in)
        || (src0 == SRC_RAM && rd_addr >= RAM_BITS); // RL15
    assign multi0 = (src0 == SRC_ROM) ? px_index <= ROM_MULTI_LAST // RL5
        : ((src0 == SRC_GEN) ? px_index >= SLD_H_START : rd_multi);

    slider_gen u_gen (
        .idx(px_index),
        .x(px_x),
        .y(px_y),
        .cw(cw_q),
        .ch(ch_q),
        .geo_a(ga_q),
        .geo_b(gb_q),
        .code(gen_code)
    );

    // ------------------------------------------------------------
    // Pixel pipeline: stage 1 fetch, stage 2 result
    // ------------------------------------------------------------
    logic s1_valid, s1_blank, s1_multi, s1_bank;
    logic [1:0] s1_gcode, code1;
    logic [2:0] s1_off;
    logic [3:0] s1_rcol;
    src_e s1_src;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_valid <= 1'b0;
            s1_src <= SRC_NONE;
            s1_blank <= 1'b1;
            s1_multi <= 1'b0;
        end else begin
            s1_valid <= px_valid;
            s1_src <= src0;
            s1_blank <= blank0;
            s1_multi <= multi0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rom_index <= '0;
            rom_row <= '0;
            s1_gcode <= 2'h0;
            s1_off <= 3'h0;
            s1_bank <= 1'b0;
            s1_rcol <= 4'h0;
        end else begin
            rom_index <= px_index; // RL1
            rom_row <= rom_rw[4:0];
            s1_gcode <= gen_code; // RL4
            s1_off <= rd_addr[2:0];
            s1_bank <= rd_byte[0];
            s1_rcol <= rom_col[3:0];
        end
    end

    logic [23:0] rsh;
    logic [7:0] bsh;
    assign rsh = rom_bits << {s1_rcol, 1'b0};
    assign bsh = bank_rd[s1_bank] << s1_off;

    always_comb begin
        unique case (s1_src)
            SRC_ROM: code1 = s1_multi ? rsh[23:22] : {1'b0, rsh[22]};
            SRC_GEN: code1 = s1_gcode;
            SRC_RAM: code1 = s1_multi ? bsh[7:6] : {1'b0, bsh[7]}; // RL13
            SRC_NONE: code1 = 2'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pix_valid <= 1'b0;
            pix_code <= 2'h0;
            pix_multi <= 1'b0;
            pix_blank <= 1'b1;
        end else begin
            pix_valid <= s1_valid;
            pix_code <= s1_blank ? 2'h0 : code1; // RL14
            pix_multi <= s1_multi;
            pix_blank <= s1_blank;
        end
    end

    // ------------------------------------------------------------
    // Read-back and subaddress auto-increment
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = reg_addr == REG_CELL_W ? {2'b00, cw_q}
        : reg_addr == REG_CELL_H ? {2'b00, ch_q}
        : reg_addr == REG_GEO_A ? ga_q
        : reg_addr == REG_GEO_B ? gb_q
        : reg_addr == REG_MS_LO ? ms_q[7:0]
        : reg_addr == REG_MS_HI ? {7'h00, ms_q[8]}
        : reg_addr == REG_SEL_LO ? sel_q[7:0]
        : reg_addr == REG_SEL_HI ? {single_q, 6'h00, sel_q[8]}
        : reg_addr == REG_MASK ? mask_q
        : reg_addr == REG_CUR_LO ? cur_q[7:0]
        : reg_addr == REG_CUR_HI ? cur_q[15:8] : 8'h00;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
            next_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : rdata_q;
            if (reg_wr || reg_rd) begin
                next_q <= wr_dat ? REG_DATA : reg_addr + 8'h01; // RL23
            end
        end
    end
    assign reg_rdata = rdata_q;
    assign reg_next_addr = next_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_select;
        wr_sel;
    endsequence
    sequence s_data;
        wr_dat && !wr_sel;
    endsequence

    AST_ROM_INDEX: assert property ( // RL1
        px_valid && px_rom && px_index <= ROM_LAST |=> rom_index
        == $past(px_index)) else $error("ROM index not forwarded");
    AST_ROM_CENTRE: assert property ( // RL2
        px_valid && px_rom && px_index <= ROM_LAST && cw_q == ROM_W
        && ch_q == ROM_H && px_y < 5'(ROM_H) |=> rom_row == $past(px_y))
        else $error("native ROM glyph row moved");
    AST_GEN_SIZE: assert property ( // RL3
        px_valid && px_rom && px_index >= GEN_FIRST && px_index <= GEN_LAST
        && {1'b0, px_x} >= cw_q |-> ##2 pix_valid && pix_blank)
        else $error("generated glyph drawn outside cell");
    AST_ROM_MULTI: assert property ( // RL5
        px_valid && px_rom && px_index <= ROM_LAST |-> ##2
        pix_multi == ($past(px_index, 2) <= ROM_MULTI_LAST))
        else $error("ROM colour mode wrong");
    AST_DATA_STEP: assert property ( // RL21
        s_data |=> cur_q == $past(cur_q) + BYTE_STEP)
        else $error("bit address did not advance by eight");
    AST_SELECT_BASE: assert property ( // RL21
        s_select |=> cur_q == $past(sel_base))
        else $error("bit address not recomputed on select");
    AST_AUTOINC: assert property ( // RL23
        wr_dat |=> reg_next_addr == REG_DATA)
        else $error("subaddress left the data register");
    AST_SINGLE_MASK: assert property ( // RL22
        wr_dat && single_q && {cur_q[20:3], 3'b000} >= end_q
        |-> wmask == 16'h0000) else $error("write past glyph end");
    AST_MONO_EQ: assert property ( // RL24
        px_valid && !px_rom && px_index == ms_q |-> ##2 !pix_multi)
        else $error("start index not single colour");
    AST_MULTI_LOW: assert property ( // RL16
        px_valid && !px_rom && px_index < ms_q |-> ##2 pix_multi)
        else $error("index below start not multicolour");

endmodule

// ### hdl/osd_glyph_pkg.sv
// Shared constants for the on-screen-display glyph source
package osd_glyph_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int IDX_W = 9;
    localparam int POS_W = 5;
    localparam int SIZE_W = 6;
    localparam int BA_W = 21;
    localparam int BANK_AW = 11;
    localparam int BYTE_AW = 12;
    localparam int NIB_W = 4;

    // ------------------------------------------------------------
    // Glyph index map
    // ------------------------------------------------------------
    localparam logic [8:0] ROM_LAST = 9'h15F;
    localparam logic [8:0] ROM_MULTI_LAST = 9'h02F;
    localparam logic [8:0] GEN_FIRST = 9'h160;
    localparam logic [8:0] GEN_LAST = 9'h1F6;
    localparam logic [8:0] SLD_H_START = 9'h1D2;
    localparam logic [8:0] SLD_H_MID = 9'h1D3;
    localparam logic [8:0] SLD_H_END = 9'h1E3;
    localparam logic [8:0] SLD_V_END = 9'h1E4;
    localparam logic [8:0] SLD_V_MID = 9'h1E5;
    localparam logic [8:0] SLD_V_START = 9'h1F6;
    localparam logic [5:0] ROM_W = 6'h0C;
    localparam logic [5:0] ROM_H = 6'h12;
    localparam int SLD_RES_SH = 4;

    // ------------------------------------------------------------
    // Font RAM
    // ------------------------------------------------------------
    localparam logic [20:0] RAM_BITS = 21'h008000;
    localparam logic [20:0] BYTE_STEP = 21'h000008;

    // ------------------------------------------------------------
    // Register subaddresses, fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CELL_W = 8'h00;
    localparam logic [7:0] REG_CELL_H = 8'h01;
    localparam logic [7:0] REG_GEO_A = 8'h02;
    localparam logic [7:0] REG_GEO_B = 8'h03;
    localparam logic [7:0] REG_MS_LO = 8'h04;
    localparam logic [7:0] REG_MS_HI = 8'h05;
    localparam logic [7:0] REG_SEL_LO = 8'h06;
    localparam logic [7:0] REG_SEL_HI = 8'h07;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h09;
    localparam logic [7:0] REG_CUR_LO = 8'h0A;
    localparam logic [7:0] REG_CUR_HI = 8'h0B;
    localparam int GA_OFS_LSB = 0;
    localparam int GA_BRD_LSB = 4;
    localparam int GB_GAP_LSB = 0;
    localparam int GB_STYLE_BIT = 4;
    localparam int SEL_SINGLE_BIT = 7;
    localparam logic [5:0] CELL_W_RST = 6'h0C;
    localparam logic [5:0] CELL_H_RST = 6'h12;
    localparam logic [7:0] GEO_RST = 8'h00;
    localparam logic [8:0] MS_RST = 9'h000;
    localparam logic [7:0] MASK_RST = 8'hFF;

    typedef enum logic [1:0] {SRC_RAM, SRC_ROM, SRC_GEN, SRC_NONE} src_e;

endpackage

// ### hdl/slider_gen.sv
// Procedural border and slider glyph generator
module slider_gen (
    // Glyph and pixel
    input wire logic [osd_glyph_pkg::IDX_W-1:0] idx,
    input wire logic [osd_glyph_pkg::POS_W-1:0] x,
    input wire logic [osd_glyph_pkg::POS_W-1:0] y,
    // Cell size and slider shape
    input wire logic [osd_glyph_pkg::SIZE_W-1:0] cw,
    input wire logic [osd_glyph_pkg::SIZE_W-1:0] ch,
    input wire logic [7:0] geo_a,
    input wire logic [7:0] geo_b,
    // 0 background, 1 border or line, 2 slider core
    output logic [1:0] code
);
    import osd_glyph_pkg::*;

    // ------------------------------------------------------------
    // Border and line glyphs
    // ------------------------------------------------------------
    logic [6:0] n;
    logic [5:0] t, xx, yy, hc, vc;
    logic line;
    assign n = 7'(idx - GEN_FIRST);
    assign t = 6'(1) + 6'(cw[5:4]);
    assign xx = {1'b0, x};
    assign yy = {1'b0, y};
    assign hc = 6'(ch >> 1);
    assign vc = 6'(cw >> 1);
    assign line = (n[0] && yy < t) || (n[1] && yy + t >= ch)
        || (n[2] && xx < t) || (n[3] && xx + t >= cw)
        || (n[4] && yy >= hc && yy < hc + t)
        || (n[5] && xx >= vc && xx < vc + t);

    // ------------------------------------------------------------
    // Slider parts, mapped onto along (u) and across (v) axes
    // ------------------------------------------------------------
    logic vert, start, stop, mid, style, fill;
    logic [5:0] u, lu, v, lv, dv, du, o, b, g, ob, obg;
    logic [4:0] grade;
    logic [10:0] lim;
    assign vert = idx >= SLD_V_END;
    assign start = idx == SLD_H_START || idx == SLD_V_START; // RL9
    assign stop = idx == SLD_H_END || idx == SLD_V_END;
    assign mid = !start && !stop;
    assign u = vert ? 6'(ch - 6'(1) - yy) : xx;
    assign lu = vert ? ch : cw;
    assign v = vert ? xx : yy;
    assign lv = vert ? cw : ch;
    assign dv = (v < 6'(lv - v - 6'(1))) ? v : 6'(lv - v - 6'(1));
    assign du = start ? u : (stop ? 6'(lu - u - 6'(1)) : 6'h3F);
    assign o = 6'(geo_a[GA_OFS_LSB +: NIB_W]);
    assign b = 6'(geo_a[GA_BRD_LSB +: NIB_W]);
    assign g = 6'(geo_b[GB_GAP_LSB +: NIB_W]);
    assign style = geo_b[GB_STYLE_BIT];
    assign ob = o + b;
    assign obg = ob + g;
    assign grade = 5'(idx - (vert ? SLD_V_MID : SLD_H_MID));
    assign lim = 11'((11'(grade) * 11'(lu)) >> SLD_RES_SH); // RL10
    assign fill = style ? (11'(u) == lim) : (11'(u) < lim); // RL8

    logic band, ring, core;
    assign band = dv >= o && du >= o;
    assign ring = band && (dv < ob || du < ob);
    assign core = dv >= obg && du >= obg;

    always_comb begin
        if (idx < SLD_H_START) begin
            code = line ? 2'h1 : 2'h0;
        end else if (ring) begin
            code = 2'h1;
        end else if (core && mid && fill) begin
            code = 2'h2;
        end else begin
            code = 2'h0;
        end
    end

endmodule

// ### test/font_rom_model.sv
// Font ROM row model driving the glyph source ROM port
module font_rom_model (
    // ROM address
    input wire logic [8:0] rom_index,
    input wire logic [4:0] rom_row,
    // ROM row data, answered in the same cycle
    output logic [23:0] rom_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // Row pattern changes with glyph and row so wrong addressing shows
    assign rom_bits = {2{rom_index[7:0] ^ {3'h0, rom_row}, rom_index[3:0]}};
endmodule

// ### test/test_osd_font_glyph_source.sv
// Self-checking bench for the glyph source
module test_osd_font_glyph_source;
    timeunit 1ns;
    timeprecision 1ps;
    import osd_glyph_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0] reg_next_addr, rd_v, v2, mask_m;
    logic px_valid = 1'b0, px_rom = 1'b0, pix_valid, pix_multi, pix_blank;
    logic [8:0] px_index = 9'h000, rom_index, g;
    logic [4:0] px_x = 5'h00, px_y = 5'h00, rom_row;
    logic [23:0] rom_bits;
    logic [1:0] pix_code;
    logic [7:0] ra [6] = '{REG_CELL_W, REG_CELL_H, REG_GEO_A, REG_MASK,
        REG_DATA, 8'h3F};
    logic [7:0] re [6] = '{8'h0C, 8'h12, 8'h00, 8'hFF, 8'h00, 8'h00};
    int error_cnt = 0, samples_checked = 0, cycles = 0, y, cur_m, base_m;
    integer seed = 32'hD423FF4A;
    bit ram_m [0:32767];
    bit single_q;
    osd_font_glyph_source dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_next_addr(reg_next_addr),
        .px_valid(px_valid), .px_rom(px_rom), .px_index(px_index),
        .px_x(px_x), .px_y(px_y), .rom_index(rom_index), .rom_row(rom_row),
        .rom_bits(rom_bits), .pix_valid(pix_valid), .pix_code(pix_code),
        .pix_multi(pix_multi), .pix_blank(pix_blank));
    font_rom_model rom (.rom_index(rom_index), .rom_row(rom_row),
        .rom_bits(rom_bits));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    task automatic sel(input logic [8:0] i, input bit s, input logic [7:0] m);
        wr(REG_SEL_LO, i[7:0]);
        wr(REG_SEL_HI, {s, 6'h00, i[8]});
        wr(REG_MASK, m);
        base_m = i * 64;
        cur_m = base_m;
        single_q = s;
        mask_m = m;
    endtask
    task automatic put(input logic [7:0] d);
        wr(REG_DATA, d);
        for (int i = 0; i < 8; i++) begin
            if (mask_m[7 - i] && !(single_q && cur_m + i >= base_m + 64))
                ram_m[cur_m + i] = d[7 - i];
        end
        cur_m += 8;
        chk(reg_next_addr, REG_DATA);
    endtask
    function automatic int rom_px(logic [8:0] i, int r, int x);
        logic [23:0] b;
        b = {2{i[7:0] ^ 8'(r), i[3:0]}};
        if (i <= ROM_MULTI_LAST)
            return int'(b[23 - 2 * x -: 2]);
        return int'(b[22 - 2 * x]);
    endfunction
    task automatic px(input bit r, input logic [8:0] i, input int x, yy,
                      input int c, m, input bit b);
        @(posedge clk);
        #1 px_valid = 1'b1;
        px_rom = r;
        px_index = i;
        px_x = x[4:0];
        px_y = yy[4:0];
        @(posedge clk);
        #1 px_valid = 1'b0;
        chk({7'h00, pix_valid}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, pix_valid}, 8'h01);
        chk({7'h00, pix_blank}, {7'h00, b});
        if (c >= 0) chk({6'h00, pix_code}, 8'(c));
        if (m >= 0) chk({7'h00, pix_multi}, 8'(m));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        foreach (ra[k]) begin
            rd(ra[k], rd_v);
            chk(rd_v, re[k]);
        end
        for (int k = 2; k < 4; k++) begin
            v2 = 8'($random(seed));
            wr(8'(k), v2);
            rd(8'(k), rd_v);
            chk(rd_v, v2);
        end
        for (int k = 0; k < 48; k++) begin
            g = (k < 24) ? 9'h020 : 9'h061;
            y = k / 12 % 2 * 17;
            px(1'b1, g, k % 12, y, rom_px(g, y, k % 12), int'(k < 24), 1'b0);
        end
        px(1'b1, 9'h020, 12, 0, 0, -1, 1'b1);
        px(1'b1, 9'h1F7, 0, 0, 0, -1, 1'b1);
        px(1'b1, 9'h1D2, 0, 0, -1, 1, 1'b0);
        px(1'b1, 9'h160, 0, 0, -1, 0, 1'b0);
        px(1'b1, 9'h161, 0, 0, 1, 0, 1'b0);
        px(1'b1, 9'h1D2, 12, 0, 0, -1, 1'b1);
        wr(REG_GEO_A, 8'h11);
        wr(REG_GEO_B, 8'h00);
        px(1'b1, 9'h1D2, 1, 1, 1, 1, 1'b0);
        px(1'b1, 9'h1E2, 5, 5, 2, 1, 1'b0);
        wr(REG_GEO_B, 8'h10);
        px(1'b1, 9'h1E2, 11, 5, 2, 1, 1'b0);
        px(1'b1, 9'h1E2, 5, 5, 0, 1, 1'b0);
        wr(REG_CELL_W, 8'h0E);
        px(1'b1, 9'h020, 0, 0, 0, -1, 1'b1);
        px(1'b1, 9'h020, 1, 0, rom_px(9'h020, 0, 0), 1, 1'b0);
        wr(REG_CELL_W, 8'h0A);
        px(1'b1, 9'h020, 0, 0, rom_px(9'h020, 0, 1), 1, 1'b0);
        wr(REG_CELL_W, 8'h08);
        wr(REG_CELL_H, 8'h08);
        sel(9'h006, 1'b0, 8'hFF);
        repeat (9) put(8'($random(seed)));
        sel(9'h005, 1'b1, 8'hFF);
        repeat (9) put(8'($random(seed)));
        sel(9'h005, 1'b1, 8'h0F);
        put(8'($random(seed)));
        rd(REG_CUR_LO, rd_v);
        chk(rd_v, 8'(cur_m));
        rd(REG_CUR_HI, rd_v);
        chk(rd_v, 8'(cur_m >> 8));
        for (int n = 0; n < 128; n++)
            px(1'b0, 9'(5 + n / 64), n % 8, n / 8 % 8, int'(ram_m[320 + n]),
               0, 1'b0);
        wr(REG_MS_LO, 8'h06);
        px(1'b0, 9'h005, 0, 0, -1, 1, 1'b0);
        px(1'b0, 9'h006, 0, 0, -1, 0, 1'b0);
        wr(REG_MS_LO, 8'h00);
        px(1'b0, 9'h000, 0, 0, -1, 0, 1'b0);
        wr(REG_MS_HI, 8'h01);
        px(1'b0, 9'h0FF, 0, 0, -1, 1, 1'b0);
        wrap_up();
    end
endmodule
